// ### tfl_timer_flags.sv
// timer counter with capture/compare flags, two-step flag clear and stop/wait behaviour
// assumes an apb master on ref_clk and capture pins from outside the clock domain
//
// Contract
// - read-only status: bits 7..3 hold the five flags, bits 2..1 the sampled levels, bit 0 reads zero
// - capture one flag sets on selected edge of capture pin one
// - capture one flag clears after status access then capture one low byte access
// - capture two flag sets on selected edge of capture pin two
// - capture two flag clears after status access then capture two low byte access
// - compare one flag sets when compare one equals the counter
// - compare one flag clears after status access then compare one low access
// - wrap flag sets when counter rolls from all ones to zero
// - wrap flag clears after status access then counter low byte access
// - compare two flag sets when compare two equals the counter
// - compare two flag clears after status access then compare two low access
// - compare one match loads capture pin one level into sampled level one
// - compare two match loads capture pin two level into sampled level two
// - any status read or write arms clearing of each flag then set
// - alternate counter mirrors counter, reads never touch wrap flag
// - timer keeps counting during wait mode
// - reset ending wait forces counter to FFFC
// - enabled timer interrupt wakes the processor from wait
// - stop halts the counter and keeps its value
// - reset ending stop forces counter to FFFC
// - stop edge loads first data and arms capture silently; flag appears on wakeup
// - reset ending stop discards any capture armed during stop
// - polarity bit one picks rising edges, zero picks falling edges
// - capture raises interrupt only when its enable bit is set
`include "tfl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tfl_timer_flags #(
    parameter int ADDR_W   = 8,
    parameter int PRESCALE = `TFL_PRESCALE
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic              pready,
    output var  logic [31:0]       prdata,
    output var  logic              pslverr,
    input  wire logic              capture_pin_one,
    input  wire logic              capture_pin_two,
    input  wire logic              wait_mode,
    input  wire logic              stop_mode,
    output var  logic              timer_irq,
    output var  logic              wake_request
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic tfl_mapped(input logic [5:0] idx);
        logic m;
        m = 1'b0;
        if (idx >= `TFL_IDX_CAP1_HI && idx <= `TFL_IDX_STATUS) begin
            m = 1'b1;
        end
        return m;
    endfunction

    // low byte register whose access completes a flag's clear
    function automatic logic [5:0] tfl_low_idx(input int f);
        logic [5:0] r;
        case (f)
            `TFL_F_CAP1: r = `TFL_IDX_CAP1_LO;
            `TFL_F_CAP2: r = `TFL_IDX_CAP2_LO;
            `TFL_F_CMP1: r = `TFL_IDX_CMP1_LO;
            `TFL_F_WRAP: r = `TFL_IDX_CNT_LO;
            default:     r = `TFL_IDX_CMP2_LO;
        endcase
        return r;
    endfunction

    localparam logic [7:0] PRESC_LAST = 8'(PRESCALE - 1);

    tfl_pkg::tfl_state_t cur;
    tfl_pkg::tfl_state_t next_st;

    logic       acc;
    logic [5:0] idx;
    logic       tick;
    logic       run;
    logic [1:0] edge_seen;
    logic [1:0] pol;
    logic [15:0] next_cnt;
    logic [7:0] rd_byte;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        next_st   = cur;
        idx       = paddr[7:2];
        acc       = psel && penable && cur.pready;
        tick      = (cur.presc == PRESC_LAST);
        run       = !stop_mode && !cur.ctrl1[`TFL_C1_TIMER_OFF];
        pol       = {cur.ctrl2[`TFL_C2_POL_TWO], cur.ctrl2[`TFL_C2_POL_ONE]};
        next_cnt  = cur.counter + 16'h0001;
        rd_byte   = 8'h00;

        // pins pass two flops; edges are taken on the second and third
        next_st.sync1 = {capture_pin_two, capture_pin_one};
        next_st.sync2 = cur.sync1;
        next_st.prev  = cur.sync2;
        next_st.stop_d = stop_mode;
        for (int i = 0; i < 2; i++) begin
            edge_seen[i] = pol[i] ? (cur.sync2[i] && !cur.prev[i])
                                  : (!cur.sync2[i] && cur.prev[i]);
        end

        // ---------------------------------------------------------
        // apb read data, one wait state
        // ---------------------------------------------------------
        case (idx)
            `TFL_IDX_CAP1_HI: rd_byte = cur.cap[0][15:8];
            `TFL_IDX_CAP1_LO: rd_byte = cur.cap[0][7:0];
            `TFL_IDX_CAP2_HI: rd_byte = cur.cap[1][15:8];
            `TFL_IDX_CAP2_LO: rd_byte = cur.cap[1][7:0];
            `TFL_IDX_CMP1_HI: rd_byte = cur.cmp[0][15:8];
            `TFL_IDX_CMP1_LO: rd_byte = cur.cmp[0][7:0];
            `TFL_IDX_CMP2_HI: rd_byte = cur.cmp[1][15:8];
            `TFL_IDX_CMP2_LO: rd_byte = cur.cmp[1][7:0];
            `TFL_IDX_CNT_HI:  rd_byte = cur.counter[15:8];
            `TFL_IDX_CNT_LO:  rd_byte = cur.counter[7:0];
            `TFL_IDX_ALT_HI:  rd_byte = cur.counter[15:8];
            `TFL_IDX_ALT_LO:  rd_byte = cur.counter[7:0];
            `TFL_IDX_CTRL1:   rd_byte = cur.ctrl1;
            `TFL_IDX_CTRL2:   rd_byte = cur.ctrl2;
            `TFL_IDX_STATUS:  rd_byte = {cur.flg, cur.lvl[0], cur.lvl[1], 1'b0};
            default:          rd_byte = 8'h00;
        endcase

        // error stands with pready only; a refused access reads zero
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && penable && !cur.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = !tfl_mapped(idx) || (paddr[1:0] != 2'b00);
            next_st.prdata  = next_st.pslverr ? 32'h00000000 : {24'h000000, rd_byte};
        end

        // ---------------------------------------------------------
        // register side effects at the completing edge
        // ---------------------------------------------------------
        // clears come first so that a same-cycle hardware set wins
        if (acc && !cur.pslverr) begin
            if (idx == `TFL_IDX_STATUS) begin
                next_st.arm = cur.arm | cur.flg;
            end
            for (int f = 0; f < 5; f++) begin
                if (idx == tfl_low_idx(f) && cur.arm[f]) begin
                    next_st.flg[f] = 1'b0;
                    next_st.arm[f] = 1'b0;
                end
            end
            if (!pwrite) begin
                // high byte read freezes the capture until the low byte is read
                if (idx == `TFL_IDX_CAP1_HI) next_st.inhib[0] = 1'b1;
                if (idx == `TFL_IDX_CAP1_LO) next_st.inhib[0] = 1'b0;
                if (idx == `TFL_IDX_CAP2_HI) next_st.inhib[1] = 1'b1;
                if (idx == `TFL_IDX_CAP2_LO) next_st.inhib[1] = 1'b0;
            end else begin
                case (idx)
                    `TFL_IDX_CTRL1:   next_st.ctrl1 = pwdata[7:0];
                    `TFL_IDX_CTRL2:   next_st.ctrl2 = pwdata[7:0];
                    `TFL_IDX_CMP1_HI: next_st.cmp[0][15:8] = pwdata[7:0];
                    `TFL_IDX_CMP1_LO: next_st.cmp[0][7:0] = pwdata[7:0];
                    `TFL_IDX_CMP2_HI: next_st.cmp[1][15:8] = pwdata[7:0];
                    `TFL_IDX_CMP2_LO: next_st.cmp[1][7:0] = pwdata[7:0];
                    default: ;
                endcase
            end
        end

        // ---------------------------------------------------------
        // free-running counter, compares and sampled levels
        // ---------------------------------------------------------
        // stop or timer-off freezes counter and prescaler alike
        if (run) begin
            next_st.presc = cur.presc + 8'h01;
            if (tick) begin
                next_st.presc   = 8'h00;
                next_st.counter = next_cnt;
                if (cur.counter == `TFL_CNT_TOP) begin
                    next_st.flg[`TFL_F_WRAP] = 1'b1;
                end
                if (next_cnt == cur.cmp[0]) begin
                    next_st.flg[`TFL_F_CMP1] = 1'b1;
                    next_st.lvl[0] = cur.sync2[0];
                end
                if (next_cnt == cur.cmp[1]) begin
                    next_st.flg[`TFL_F_CMP2] = 1'b1;
                    next_st.lvl[1] = cur.sync2[1];
                end
            end
        end

        // ---------------------------------------------------------
        // capture channels
        // ---------------------------------------------------------
        for (int i = 0; i < 2; i++) begin
            if (edge_seen[i]) begin
                if (stop_mode) begin
                    // only the first edge in stop keeps its data
                    if (!cur.stop_armed[i]) begin
                        next_st.stop_armed[i] = 1'b1;
                        if (!cur.inhib[i]) next_st.cap[i] = cur.counter;
                    end
                end else begin
                    if (!cur.inhib[i]) next_st.cap[i] = cur.counter;
                    next_st.flg[`TFL_F_CAP1 - i] = 1'b1;
                end
            end
            if (cur.stop_d && !stop_mode && cur.stop_armed[i]) begin
                next_st.flg[`TFL_F_CAP1 - i] = 1'b1;
                next_st.stop_armed[i] = 1'b0;
            end
        end

        // ---------------------------------------------------------
        // interrupt and wake request
        // ---------------------------------------------------------
        next_st.irq  = |(next_st.flg & next_st.ctrl1[7:3]);
        next_st.wake = next_st.irq && wait_mode;

        // ---------------------------------------------------------
        // synchronous reset
        // ---------------------------------------------------------
        if (rst) begin
            next_st         = '0;
            // pin chain keeps running so no false edge follows reset
            next_st.sync1   = {capture_pin_two, capture_pin_one};
            next_st.sync2   = cur.sync1;
            next_st.prev    = cur.sync2;
            next_st.counter = `TFL_CNT_RESET;
            next_st.cmp[0]  = `TFL_CMP_RESET;
            next_st.cmp[1]  = `TFL_CMP_RESET;
            next_st.ctrl1   = `TFL_CTRL_RESET;
            next_st.ctrl2   = `TFL_CTRL_RESET;
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        cur <= next_st;
    end

    assign pready       = cur.pready;
    assign prdata       = cur.prdata;
    assign pslverr      = cur.pslverr;
    assign timer_irq    = cur.irq;
    assign wake_request = cur.wake;

endmodule

`default_nettype wire

// ### tfl_defines.svh
// register indices, bit positions and reset values of the timer flag block
// assumes byte address = 4 * index on a 32-bit apb word bus
`ifndef TFL_DEFINES_SVH
`define TFL_DEFINES_SVH
// -----------------------------------------------------------------
// register indices
// -----------------------------------------------------------------
`define TFL_IDX_CAP1_HI   6'h10
`define TFL_IDX_CAP1_LO   6'h11
`define TFL_IDX_CMP1_HI   6'h12
`define TFL_IDX_CMP1_LO   6'h13
`define TFL_IDX_CAP2_HI   6'h14
`define TFL_IDX_CAP2_LO   6'h15
`define TFL_IDX_CMP2_HI   6'h16
`define TFL_IDX_CMP2_LO   6'h17
`define TFL_IDX_CNT_HI    6'h18
`define TFL_IDX_CNT_LO    6'h19
`define TFL_IDX_ALT_HI    6'h1A
`define TFL_IDX_ALT_LO    6'h1B
`define TFL_IDX_CTRL1     6'h1C
`define TFL_IDX_CTRL2     6'h1D
`define TFL_IDX_STATUS    6'h1E
// -----------------------------------------------------------------
// flag vector positions (status bits 7..3)
// -----------------------------------------------------------------
`define TFL_F_CAP1        4
`define TFL_F_CAP2        3
`define TFL_F_CMP1        2
`define TFL_F_WRAP        1
`define TFL_F_CMP2        0
// -----------------------------------------------------------------
// control bit positions
// -----------------------------------------------------------------
`define TFL_C1_TIMER_OFF  0
`define TFL_C2_POL_ONE    7
`define TFL_C2_POL_TWO    6
// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define TFL_CNT_RESET     16'hFFFC
`define TFL_CNT_TOP       16'hFFFF
`define TFL_CMP_RESET     16'h0000
`define TFL_CTRL_RESET    8'h00
`define TFL_PRESCALE      4
`endif

// ### tfl_pkg.sv
// types of the timer flag block
// assumes tfl_defines.svh for all numeric constants
package tfl_pkg;
    // -------------------------------------------------------------
    // whole register state of the block
    // -------------------------------------------------------------
    typedef struct packed {
        logic [15:0]       counter;
        logic [7:0]        presc;
        logic [1:0][15:0]  cap;
        logic [1:0][15:0]  cmp;
        logic [7:0]        ctrl1;
        logic [7:0]        ctrl2;
        logic [4:0]        flg;
        logic [4:0]        arm;
        logic [1:0]        lvl;
        logic [1:0]        sync1;
        logic [1:0]        sync2;
        logic [1:0]        prev;
        logic [1:0]        stop_armed;
        logic [1:0]        inhib;
        logic              stop_d;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              irq;
        logic              wake;
    } tfl_state_t;
endpackage

// ### tfl_pin_model.sv
// capture pin driver standing in for the outside world
// assumes the caller runs on ref_clk and waits for the pin to settle
`timescale 1ns/1ps
`default_nettype none
module tfl_pin_model (
    input  wire logic ref_clk,
    output var  logic pin_one,
    output var  logic pin_two
);
    initial begin
        pin_one = 1'b1;
        pin_two = 1'b0;
    end
    // hold six edges so the two-flop synchroniser and capture settle
    task automatic drive(input logic a, input logic b);
        @(posedge ref_clk);
        pin_one <= a;
        pin_two <= b;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ### tfl_timer_flags_monitor.sv
// port assertions of the timer flag block
// assumes one wait state apb slave on ref_clk, bound below
`timescale 1ns/1ps
`default_nettype none
module tfl_timer_flags_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              wait_mode,
    input wire logic              timer_irq,
    input wire logic              wake_request
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic ok;
    assign ok = paddr[1:0] == 2'b00 && paddr[7:2] >= 6'h10 && paddr[7:2] <= 6'h1E;
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no pready after access phase");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_refused: assert property (pready && !ok |-> pslverr && prdata == 32'h0)
        else $error("bad address not refused");
    a_ok_mapped: assert property (pready && ok |-> !pslverr)
        else $error("mapped address refused");
    a_status_bit_zero: assert property (pready && !pwrite && paddr[7:2] == 6'h1E |-> prdata[0] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("status read has bits outside 7..1");
    a_wake_needs_wait: assert property (!wait_mode && !$past(wait_mode) |-> !wake_request)
        else $error("wake request outside wait");
    a_wake_on_irq: assert property ((wait_mode && timer_irq) [*2] |-> wake_request)
        else $error("no wake request on irq in wait");
endmodule
bind tfl_timer_flags tfl_timer_flags_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .wait_mode(wait_mode),
    .timer_irq(timer_irq), .wake_request(wake_request)
);
`default_nettype wire

// ### tb_top.sv
// self-checking bench of the timer flag block over apb
// assumes PRESCALE 1 so the counter ticks every ref_clk cycle
`include "tfl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [15:0] CNT_RST = `TFL_CNT_RESET;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        pin_one;
    logic        pin_two;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        timer_irq;
    logic        wake_request;
    logic [1:0]  offs = 2'b00;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic        err;
    int          errors = 0;
    int          samples_checked = 0;
    always #5 ref_clk = ~ref_clk;
    tfl_timer_flags #(.ADDR_W(8), .PRESCALE(1)) u_tfl_timer_flags (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .capture_pin_one(pin_one), .capture_pin_two(pin_two), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .timer_irq(timer_irq), .wake_request(wake_request)
    );
    tfl_pin_model u_tfl_pin_model (.ref_clk(ref_clk), .pin_one(pin_one), .pin_two(pin_two));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, offs};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic r(input logic [5:0] idx);
        apb(1'b0, idx, 8'h00);
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        // ----------------------------------------------------------
        // wrap from FFFC, compares at reset value 0000, two-step clears
        // ----------------------------------------------------------
        repeat (8) @(posedge ref_clk);
        r(`TFL_IDX_STATUS); chk("status", 32'h3C, rd);
        r(`TFL_IDX_ALT_LO);
        r(`TFL_IDX_STATUS); chk("status", 32'h3C, rd);
        r(`TFL_IDX_CNT_LO);
        r(`TFL_IDX_STATUS); chk("status", 32'h2C, rd);
        apb(1'b1, `TFL_IDX_CMP1_HI, 8'h03);
        apb(1'b1, `TFL_IDX_CMP1_LO, 8'h00);
        r(`TFL_IDX_STATUS); chk("status", 32'h0C, rd);
        apb(1'b1, `TFL_IDX_CMP2_HI, 8'h03);
        apb(1'b1, `TFL_IDX_CMP2_LO, 8'h00);
        r(`TFL_IDX_STATUS); chk("status", 32'h04, rd);
        // ----------------------------------------------------------
        // captures: pin one falling, pin two rising
        // ----------------------------------------------------------
        apb(1'b1, `TFL_IDX_CTRL2, 8'h40);
        u_tfl_pin_model.drive(1'b0, 1'b1);
        r(`TFL_IDX_STATUS); chk("status", 32'hC4, rd);
        r(`TFL_IDX_CAP1_LO);
        r(`TFL_IDX_STATUS); chk("status", 32'h44, rd);
        r(`TFL_IDX_CAP2_LO);
        r(`TFL_IDX_STATUS); chk("status", 32'h04, rd);
        r(`TFL_IDX_CNT_HI);
        for (int i = 0; i < 400 && rd[7:0] < 8'h03; i++) r(`TFL_IDX_CNT_HI);
        r(`TFL_IDX_STATUS); chk("status", 32'h2A, rd);
        // ----------------------------------------------------------
        // interrupt, wake and wait
        // ----------------------------------------------------------
        apb(1'b1, `TFL_IDX_CTRL1, 8'h20);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, timer_irq});
        wait_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("wake", 32'h1, {31'h0, wake_request});
        r(`TFL_IDX_STATUS);
        r(`TFL_IDX_CNT_LO);
        rd2 = rd;
        r(`TFL_IDX_CNT_LO); chk("count runs", 32'h1, {31'h0, rd !== rd2});
        r(`TFL_IDX_CMP1_LO);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h0, {31'h0, timer_irq});
        wait_mode <= 1'b0;
        u_tfl_pin_model.drive(1'b1, 1'b1);
        u_tfl_pin_model.drive(1'b0, 1'b1);
        chk("irq", 32'h0, {31'h0, timer_irq});
        apb(1'b1, `TFL_IDX_CTRL1, 8'h80);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, timer_irq});
        // ----------------------------------------------------------
        // stop: held count, silent capture, reset discards it
        // ----------------------------------------------------------
        stop_mode <= 1'b1;
        r(`TFL_IDX_CNT_LO);
        rd2 = rd;
        u_tfl_pin_model.drive(1'b0, 1'b0);
        u_tfl_pin_model.drive(1'b0, 1'b1);
        r(`TFL_IDX_CNT_LO); chk("count held", rd2, rd);
        r(`TFL_IDX_STATUS); chk("cap2 in stop", 32'h0, {31'h0, rd[6]});
        stop_mode <= 1'b0;
        r(`TFL_IDX_STATUS); chk("cap2 after stop", 32'h1, {31'h0, rd[6]});
        r(`TFL_IDX_CAP2_LO); chk("cap2 stop data", rd2, rd);
        stop_mode <= 1'b1;
        u_tfl_pin_model.drive(1'b0, 1'b0);
        u_tfl_pin_model.drive(1'b0, 1'b1);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        r(`TFL_IDX_CNT_HI); chk("count hi", {24'h0, CNT_RST[15:8]}, rd);
        r(`TFL_IDX_CNT_LO); chk("count lo", {24'h0, CNT_RST[7:0]}, rd);
        stop_mode <= 1'b0;
        r(`TFL_IDX_STATUS); chk("cap2 after reset", 32'h0, {31'h0, rd[6]});
        r(`TFL_IDX_CAP2_LO); chk("cap2 data after reset", 32'h0, rd);
        // ----------------------------------------------------------
        // pin one rising edge, clear armed by a status write
        // ----------------------------------------------------------
        apb(1'b1, `TFL_IDX_CTRL1, 8'h80);
        apb(1'b1, `TFL_IDX_CTRL2, 8'h80);
        u_tfl_pin_model.drive(1'b1, 1'b1);
        chk("irq rising", 32'h1, {31'h0, timer_irq});
        apb(1'b1, `TFL_IDX_STATUS, 8'h00);
        r(`TFL_IDX_CAP1_LO);
        repeat (2) @(posedge ref_clk);
        chk("irq after write clear", 32'h0, {31'h0, timer_irq});
        // ----------------------------------------------------------
        // refused accesses
        // ----------------------------------------------------------
        r(6'h05);
        chk("unmapped err", 32'h1, {31'h0, err});
        offs = 2'b10;
        r(`TFL_IDX_STATUS);
        chk("misaligned err", 32'h1, {31'h0, err});
        offs = 2'b00;
        complete_run();
    end
endmodule
`default_nettype wire
